//--- verilog/ucb_pkg.sv
// register map, field positions, reset values and lookup tables of the
// serial channel configuration bank; assumes a 50 MHz sys_clk.
// Operation
// RQ1: type select 0 with interrupt enabled: any received address byte interrupts.
// RQ2: type select 1: only matching address bytes interrupt; select resets to 1.
// RQ3: interrupt control bit 0 gates the multidrop interrupt output.
// RQ4: status bit 0 reads 1 once the multidrop interrupt fired; resets 0.
// RQ5: writing 0 clears the status flag; a same-cycle set wins.
// RQ6: trigger level chosen by level mode field and fifo control bits 7:6.
// RQ7: extended control bit 0 enlarges both FIFOs to 128 bytes.
// RQ8: extended control bit 4 enables the paired-channel bypass; resets 0.
// RQ9: software writes zeros to extended control bits 3 to 1.
// RQ10: activation bit 0 makes the channel active; resets inactive.
// RQ11: base registers hold an eight-byte aligned base, reset 02e0h.
// RQ12: IRQ select low nibble chooses the interrupt line; resets 03h.
// RQ13: option bit 7 clear delays the receive clock about 5 ns.
// RQ14: option bit 6 selects level or pulse interrupt signalling.
// RQ15: option bit 5 selects original or revised receive error source.
// RQ16: option bits 1:0 pick divide by 13, 12, 1 or 1.625 of 24 MHz.
// RQ17: multidrop mode reuses the parity bit as address/data flag.
// RQ18: automatic receive control compares address bytes and may interrupt.
package ucb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL  = 8'h70;
  localparam logic [7:0] IDX_OPTIONS  = 8'hf0;
  localparam logic [7:0] IDX_MD_CTRL  = 8'hf6;
  localparam logic [7:0] IDX_MD_FLAG  = 8'hf7;
  localparam logic [7:0] IDX_EXT_CTRL = 8'hf8;

  localparam logic [7:0] RST_ACTIVATE = 8'h00;
  localparam logic [7:0] RST_BASE_HI  = 8'h02;
  localparam logic [7:0] RST_BASE_LO  = 8'he0;
  localparam logic [7:0] RST_IRQ_SEL  = 8'h03;
  localparam logic [7:0] RST_OPTIONS  = 8'h00;
  localparam logic [7:0] RST_MD_CTRL  = 8'h02;
  localparam logic [7:0] RST_MD_FLAG  = 8'h00;
  localparam logic [7:0] RST_EXT_CTRL = 8'h00;

  // writable bits of each register
  localparam logic [7:0] MSK_ACTIVATE = 8'h01;
  localparam logic [7:0] MSK_BASE_LO  = 8'hf8;
  localparam logic [7:0] MSK_IRQ_SEL  = 8'h0f;
  localparam logic [7:0] MSK_OPTIONS  = 8'he3;
  localparam logic [7:0] MSK_MD_CTRL  = 8'h03;
  localparam logic [7:0] MSK_EXT_CTRL = 8'hd1;

  localparam int BIT_ACTIVE      = 0;
  localparam int BIT_RX_CLK_NODLY = 7;
  localparam int BIT_IRQ_PULSE   = 6;
  localparam int BIT_ERR_NEW     = 5;
  localparam int BIT_CLK_LO      = 0;
  localparam int BIT_MD_ENABLE   = 0;
  localparam int BIT_MD_TYPE     = 1;
  localparam int BIT_MD_FLAG     = 0;
  localparam int BIT_DEEP_FIFO   = 0;
  localparam int BIT_BYPASS      = 4;
  localparam int BIT_LVL_LO      = 6;

  // receive clock delay: a least time, rounded up to whole cycles
  localparam int SYS_CLK_HZ      = 50_000_000;
  localparam int RX_CLK_DELAY_PS  = 5000;
  localparam int RX_CLK_DELAY_CYC = (RX_CLK_DELAY_PS * (SYS_CLK_HZ / 1_000_000) + 999_999) / 1_000_000;

  // channel clock divisor of 24 MHz, in eighths: 13, 12, 1, 1.625
  localparam logic [7:0] DIV_X8_13  = 8'h68;
  localparam logic [7:0] DIV_X8_12  = 8'h60;
  localparam logic [7:0] DIV_X8_1   = 8'h08;
  localparam logic [7:0] DIV_X8_1P6 = 8'h0d;

  // receive trigger levels, index {level mode, fifo control bits 7:6}
  localparam logic [7:0] TRIG_TABLE [16] = '{
    8'h01, 8'h04, 8'h08, 8'h0e,
    8'h10, 8'h20, 8'h30, 8'h40,
    8'h50, 8'h58, 8'h60, 8'h68,
    8'h70, 8'h74, 8'h78, 8'h7c};
endpackage

//--- verilog/ucb_rx_trigger.sv
// receive FIFO trigger level lookup, registered
// assumes sys_clk and resetn of the bank
`timescale 1ns/1ps
module ucb_rx_trigger
  import ucb_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic [1:0] levelMode,
  input  wire logic [1:0] fifoTrigSel,
  output      logic [7:0] rxTrigLevel
);
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rxTrigLevel <= TRIG_TABLE[0];
    else
      rxTrigLevel <= TRIG_TABLE[{levelMode, fifoTrigSel}]; // RQ6
  end

  chk_trig_follow: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ6
    rxTrigLevel == TRIG_TABLE[{$past(levelMode), $past(fifoTrigSel)}])
    else $error("trigger level does not follow mode and fifo bits");
endmodule

//--- verilog/ucb_irq_shaper.sv
// drives the channel interrupt as a level or a one-cycle pulse
// assumes irqSource is a synchronous level
`timescale 1ns/1ps
module ucb_irq_shaper
(
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic irqSource,
  input  wire logic pulseMode,
  output      logic irqOut
);
  logic srcDly_reg;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      srcDly_reg <= 1'b0;
    else
      srcDly_reg <= irqSource;
  end

  // pulse mode lets a shared line see one edge per event
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irqOut <= 1'b0;
    else if (pulseMode)
      irqOut <= irqSource & ~srcDly_reg; // RQ14
    else
      irqOut <= irqSource; // RQ14
  end

  chk_pulse_single: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ14
    (pulseMode && $past(pulseMode) && irqOut) |=> !irqOut)
    else $error("pulse mode interrupt lasted more than one cycle");
endmodule

//--- verilog/ucb_config_bank.sv
// serial channel configuration bank with APB slave access
// assumes APB master on sys_clk; datapath signals synchronous to sys_clk
`timescale 1ns/1ps
module ucb_config_bank
  import ucb_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output      logic [31:0]       prdata,
  output      logic              pready,
  output      logic              pslverr,
  input  wire logic              addrByteRx,
  input  wire logic              addrMatch,
  input  wire logic              autoRxCtrl,
  input  wire logic              multidrop_mode_enable,
  input  wire logic [1:0]        fifoTrigSel,
  output      logic              parityIsAddrFlag,
  output      logic              deviceActive,
  output      logic [15:0]       ioBase,
  output      logic [3:0]        irqLine,
  output      logic              rxClkDelayOn,
  output      logic              rxErrNewSel,
  output      logic [7:0]        clkDivX8,
  output      logic              deep_fifo_enable,
  output      logic              paired_channel_bypass_on,
  output      logic [7:0]        rxTrigLevel,
  output      logic              channelIrq,
  output      logic              multidropIrq
);
  if (ADDR_W < 10)
  begin : g_addr_check
    $error("ADDR_W too narrow for the register map");
  end

  logic [7:0] activate_reg;
  logic [7:0] baseHi_reg;
  logic [7:0] baseLo_reg;
  logic [7:0] irqSel_reg;
  logic [7:0] options_reg;
  logic [7:0] mdCtrl_reg;
  logic       mdFlag_reg;
  logic [7:0] extCtrl_reg;
  logic [7:0] regIdx;
  logic       idxHigh;
  logic       accessDone;
  logic       wrDone;
  logic       mapped;
  logic [7:0] wByte;
  logic [7:0] rdByte;
  logic       mdEvent;
  logic       mdFlag_next;
  logic       mdGated;
  logic       irqPulse;

  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign regIdx  = paddr[9:2];
  assign idxHigh = (ADDR_W > 10) ? |(paddr >> 10) : 1'b0;
  assign accessDone = psel & penable;
  assign wByte   = pwdata[7:0];

  always_comb
  begin
    mapped = 1'b0;
    rdByte = 8'h00;
    if (!idxHigh)
    begin
      case (regIdx)
        IDX_ACTIVATE:
        begin
          mapped = 1'b1;
          rdByte = activate_reg;
        end
        IDX_BASE_HI:
        begin
          mapped = 1'b1;
          rdByte = baseHi_reg;
        end
        IDX_BASE_LO:
        begin
          mapped = 1'b1;
          rdByte = baseLo_reg;
        end
        IDX_IRQ_SEL:
        begin
          mapped = 1'b1;
          rdByte = irqSel_reg;
        end
        IDX_OPTIONS:
        begin
          mapped = 1'b1;
          rdByte = options_reg;
        end
        IDX_MD_CTRL:
        begin
          mapped = 1'b1;
          rdByte = mdCtrl_reg;
        end
        IDX_MD_FLAG:
        begin
          mapped = 1'b1;
          rdByte = {7'h00, mdFlag_reg}; // RQ4
        end
        IDX_EXT_CTRL:
        begin
          mapped = 1'b1;
          rdByte = extCtrl_reg;
        end
        default:
        begin
          mapped = 1'b0;
          rdByte = 8'h00;
        end
      endcase
    end
  end

  assign pslverr = accessDone & ~mapped;
  // only byte lane 0 carries register data; other lanes are ignored
  assign wrDone  = accessDone & pwrite & mapped & pstrb[0];

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= {24'h00_0000, rdByte};
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      activate_reg <= RST_ACTIVATE;
      baseHi_reg   <= RST_BASE_HI;
      baseLo_reg   <= RST_BASE_LO;
      irqSel_reg   <= RST_IRQ_SEL;
      options_reg  <= RST_OPTIONS;
      mdCtrl_reg   <= RST_MD_CTRL;
      extCtrl_reg  <= RST_EXT_CTRL;
    end
    else if (wrDone)
    begin
      case (regIdx)
        IDX_ACTIVATE: activate_reg <= wByte & MSK_ACTIVATE; // RQ10
        IDX_BASE_HI:  baseHi_reg   <= wByte; // RQ11
        IDX_BASE_LO:  baseLo_reg   <= wByte & MSK_BASE_LO; // RQ11
        IDX_IRQ_SEL:  irqSel_reg   <= wByte & MSK_IRQ_SEL; // RQ12
        IDX_OPTIONS:  options_reg  <= wByte & MSK_OPTIONS;
        IDX_MD_CTRL:  mdCtrl_reg   <= wByte & MSK_MD_CTRL;
        // reserved bits 3:1 are expected as zero and kept at zero
        IDX_EXT_CTRL: extCtrl_reg  <= wByte & MSK_EXT_CTRL; // RQ9
        default:      activate_reg <= activate_reg;
      endcase
    end
  end

  // address byte event, filtered by match when type select is 1
  assign mdEvent = addrByteRx & multidrop_mode_enable & autoRxCtrl // RQ18
                 & mdCtrl_reg[BIT_MD_ENABLE]
                 & (~mdCtrl_reg[BIT_MD_TYPE] | addrMatch); // RQ1 RQ2

  always_comb
  begin
    mdFlag_next = mdFlag_reg;
    if (wrDone && regIdx == IDX_MD_FLAG && !wByte[BIT_MD_FLAG])
      mdFlag_next = 1'b0; // RQ5
    if (mdEvent)
      mdFlag_next = 1'b1; // RQ4 RQ5
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      mdFlag_reg <= RST_MD_FLAG[0];
    else
      mdFlag_reg <= mdFlag_next;
  end

  assign mdGated = mdFlag_reg & mdCtrl_reg[BIT_MD_ENABLE]; // RQ3

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      multidropIrq <= 1'b0;
    else
      multidropIrq <= mdGated; // RQ3
  end

  ucb_irq_shaper u_shaper
  (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .irqSource (mdGated & activate_reg[BIT_ACTIVE]),
    .pulseMode (options_reg[BIT_IRQ_PULSE]), // RQ14
    .irqOut    (irqPulse)
  );
  assign channelIrq = irqPulse;

  ucb_rx_trigger u_trigger
  (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .levelMode   (extCtrl_reg[BIT_LVL_LO+1:BIT_LVL_LO]), // RQ6
    .fifoTrigSel (fifoTrigSel),
    .rxTrigLevel (rxTrigLevel)
  );

  always_comb
  begin
    case (options_reg[BIT_CLK_LO+1:BIT_CLK_LO]) // RQ16
      2'h0:    clkDivX8 = DIV_X8_13;
      2'h1:    clkDivX8 = DIV_X8_12;
      2'h2:    clkDivX8 = DIV_X8_1;
      default: clkDivX8 = DIV_X8_1P6;
    endcase
  end

  assign deviceActive     = activate_reg[BIT_ACTIVE]; // RQ10
  assign ioBase           = {baseHi_reg, baseLo_reg}; // RQ11
  assign irqLine          = irqSel_reg[3:0]; // RQ12
  // analog delay line sits outside; this only enables it
  assign rxClkDelayOn     = ~options_reg[BIT_RX_CLK_NODLY]; // RQ13
  assign rxErrNewSel      = options_reg[BIT_ERR_NEW]; // RQ15
  assign deep_fifo_enable = extCtrl_reg[BIT_DEEP_FIFO]; // RQ7
  assign paired_channel_bypass_on = extCtrl_reg[BIT_BYPASS]; // RQ8
  assign parityIsAddrFlag = multidrop_mode_enable; // RQ17

  sequence s_flagWrZero;
    wrDone && regIdx == IDX_MD_FLAG && !wByte[0];
  endsequence

  sequence s_addrIn;
    addrByteRx && multidrop_mode_enable && autoRxCtrl && mdCtrl_reg[0];
  endsequence

  chk_any_addr_irq: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ1
    (s_addrIn and (!mdCtrl_reg[1])) |=> mdFlag_reg)
    else $error("address byte did not set flag in any-address mode");

  chk_match_only: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ2
    (!mdFlag_reg && mdCtrl_reg[1] && !addrMatch && !wrDone) |=> !mdFlag_reg)
    else $error("flag set without address match");

  chk_gate_blocks: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ3
    !mdCtrl_reg[0] |=> !multidropIrq)
    else $error("multidrop interrupt passed while disabled");

  chk_flag_holds: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ4
    (mdFlag_reg && !wrDone) |=> mdFlag_reg)
    else $error("status flag dropped without a clear");

  chk_set_wins: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ5
    (s_flagWrZero and mdEvent) |=> mdFlag_reg)
    else $error("clear beat a same-cycle set");

  chk_clear_works: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ5
    (s_flagWrZero and !mdEvent) |=> !mdFlag_reg)
    else $error("writing zero did not clear the flag");

  chk_ext_reserved: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ9
    extCtrl_reg[3:1] == 3'h0)
    else $error("extended control reserved bits set");

  chk_activate_wr: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ10
    (wrDone && regIdx == IDX_ACTIVATE) |=> deviceActive == $past(wByte[0]))
    else $error("activation bit did not take the written value");

  chk_base_align: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ11
    ioBase[2:0] == 3'h0)
    else $error("base address not eight-byte aligned");

  chk_irq_line_wr: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ12
    (wrDone && regIdx == IDX_IRQ_SEL) |=> irqLine == $past(wByte[3:0]) && irqSel_reg[7:4] == 4'h0)
    else $error("irq line select did not follow write");

  chk_bypass_wr: assert property (@(posedge sys_clk) disable iff (!resetn) // RQ8
    (wrDone && regIdx == IDX_EXT_CTRL) |=> paired_channel_bypass_on == $past(wByte[4])
      && deep_fifo_enable == $past(wByte[0]))
    else $error("extended control outputs did not follow write");

  chk_unmapped_err: assert property (@(posedge sys_clk) disable iff (!resetn)
    (accessDone && !mapped) |-> pslverr)
    else $error("unmapped access not flagged");

  chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    (psel && !penable && !pwrite && !mapped) |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");
endmodule

//--- sim/test_ucb_config_bank.sv
// self-checking bench for the serial channel configuration bank
// assumes zero-wait APB slave and registered interrupt outputs
`timescale 1ns/1ps
module test_ucb_config_bank;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        addrByteRx = 1'b0, addrMatch = 1'b0, autoRxCtrl = 1'b0, multidropModeOn = 1'b0;
  logic [1:0]  fifoTrigSel = 2'b00;
  logic        parityIsAddrFlag, deviceActive, rxClkDelayOn, rxErrNewSel, deepFifo, bypassOn;
  logic        channelIrq, multidropIrq;
  logic [15:0] ioBase;
  logic [3:0]  irqLine;
  logic [7:0]  clkDivX8, rxTrigLevel, rd;
  logic        err;
  int          errCount = 0;
  int          checksDone = 0;

  ucb_config_bank ucb_config_bank_i (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .addrByteRx(addrByteRx), .addrMatch(addrMatch), .autoRxCtrl(autoRxCtrl),
    .multidrop_mode_enable(multidropModeOn), .fifoTrigSel(fifoTrigSel),
    .parityIsAddrFlag(parityIsAddrFlag), .deviceActive(deviceActive), .ioBase(ioBase),
    .irqLine(irqLine), .rxClkDelayOn(rxClkDelayOn), .rxErrNewSel(rxErrNewSel),
    .clkDivX8(clkDivX8), .deep_fifo_enable(deepFifo), .paired_channel_bypass_on(bypassOn),
    .rxTrigLevel(rxTrigLevel), .channelIrq(channelIrq), .multidropIrq(multidropIrq));

  always #10 sys_clk = ~sys_clk;

  task automatic stopTest;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      errCount++;
    end
  endtask

  // one APB transfer; ev raises an address byte during the access cycle
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic ev);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    addrByteRx <= ev;
    // only the watchdog ends a wait for the slave
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    addrByteRx <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 1'b0);
    chk(rd, exp);
    chk(err, 1'b0);
  endtask

  // address byte; taken edge, then both interrupts one edge later
  task automatic mdEvent(input logic m, input logic expIrq);
    @(posedge sys_clk);
    addrByteRx <= 1'b1;
    addrMatch <= m;
    @(posedge sys_clk);
    addrByteRx <= 1'b0;
    addrMatch <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(multidropIrq, expIrq);
    chk(channelIrq, expIrq);
  endtask

  task automatic testReset;
    logic [7:0] idx [8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hf0, 8'hf6, 8'hf7, 8'hf8};
    logic [7:0] val [8] = '{8'h00, 8'h02, 8'he0, 8'h03, 8'h00, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++)
      rdChk(idx[i], val[i]);
    chk({deviceActive, ioBase, irqLine, rxClkDelayOn, clkDivX8}, {1'b0, 16'h02e0, 4'h3, 1'b1, 8'h68});
    chk({rxTrigLevel, multidropIrq, channelIrq}, {8'h01, 2'b00});
  endtask

  task automatic testRegs;
    apb(1'b1, 8'hf8, 8'h31, 1'b0);
    rdChk(8'hf8, 8'h11);
    chk({deepFifo, bypassOn}, 2'b11);
    apb(1'b1, 8'hf8, 8'h00, 1'b0);
    rdChk(8'hf8, 8'h00);
    chk({deepFifo, bypassOn}, 2'b00);
    apb(1'b1, 8'h60, 8'h0f, 1'b0);
    apb(1'b1, 8'h61, 8'hff, 1'b0);
    rdChk(8'h61, 8'hf8);
    chk(ioBase, 16'h0ff8);
    apb(1'b1, 8'h70, 8'hff, 1'b0);
    rdChk(8'h70, 8'h0f);
    chk(irqLine, 4'hf);
    // lane 0 strobe low: the write must be dropped
    pstrb <= 4'he;
    apb(1'b1, 8'h70, 8'h05, 1'b0);
    pstrb <= 4'hf;
    rdChk(8'h70, 8'h0f);
    apb(1'b1, 8'h30, 8'hff, 1'b0);
    rdChk(8'h30, 8'h01);
    chk(deviceActive, 1'b1);
    apb(1'b0, 8'h31, 8'h00, 1'b0);
    chk({err, rd}, {1'b1, 8'h00});
  endtask

  task automatic testOptions;
    logic [7:0] div [4] = '{8'h68, 8'h60, 8'h08, 8'h0d};
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = 8'(i) | (i[0] ? 8'ha0 : 8'h5c);
      apb(1'b1, 8'hf0, v, 1'b0);
      rdChk(8'hf0, v & 8'he3);
      chk(clkDivX8, div[i]);
      chk({rxClkDelayOn, rxErrNewSel}, {~v[7], v[5]});
    end
    apb(1'b1, 8'hf0, 8'h00, 1'b0);
  endtask

  task automatic testTrigger;
    logic [7:0] lvl [16] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h10, 8'h20, 8'h30, 8'h40,
                             8'h50, 8'h58, 8'h60, 8'h68, 8'h70, 8'h74, 8'h78, 8'h7c};
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 4; s++)
      begin
        apb(1'b1, 8'hf8, {2'(m), 6'h00}, 1'b0);
        fifoTrigSel <= 2'(s);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(rxTrigLevel, lvl[m * 4 + s]);
      end
  endtask

  task automatic testMultidrop;
    chk(parityIsAddrFlag, 1'b0);
    multidropModeOn <= 1'b1;
    autoRxCtrl <= 1'b1;
    apb(1'b1, 8'hf6, 8'h01, 1'b0);
    chk(parityIsAddrFlag, 1'b1);
    mdEvent(1'b0, 1'b1);
    rdChk(8'hf7, 8'h01);
    apb(1'b1, 8'hf7, 8'h01, 1'b0);
    rdChk(8'hf7, 8'h01);
    apb(1'b1, 8'hf7, 8'h00, 1'b1);
    rdChk(8'hf7, 8'h01);
    apb(1'b1, 8'hf7, 8'h00, 1'b0);
    rdChk(8'hf7, 8'h00);
    apb(1'b1, 8'hf6, 8'h03, 1'b0);
    mdEvent(1'b0, 1'b0);
    rdChk(8'hf7, 8'h00);
    apb(1'b1, 8'hf0, 8'h40, 1'b0);
    mdEvent(1'b1, 1'b1);
    @(posedge sys_clk);
    #1;
    chk({multidropIrq, channelIrq}, 2'b10);
    apb(1'b1, 8'hf7, 8'h00, 1'b0);
    apb(1'b1, 8'hf6, 8'h02, 1'b0);
    mdEvent(1'b1, 1'b0);
    rdChk(8'hf7, 8'h00);
  endtask

  // reset in mid-run must bring every register back to its default
  task automatic testMidReset;
    fifoTrigSel <= 2'b00;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    testReset();
  endtask

  initial
  begin
    repeat (15000) @(posedge sys_clk);
    errCount++;
    stopTest();
  end

  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    testReset();
    testRegs();
    testOptions();
    testTrigger();
    testMultidrop();
    testMidReset();
    stopTest();
  end
endmodule
